// File: flash_access_pkg.sv
// Package: register map, field layout and timing for program flash access
package flash_access_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_PAGE = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0c;
    localparam logic [7:0] OFF_TABLE = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    // Control and page field positions
    localparam int GO_BIT = 15;
    localparam int ENABLE_BIT = 14;
    localparam int FAULT_BIT = 13;
    localparam int ERASE_BIT = 6;
    localparam int PAGE_CFG_BIT = 7;
    // Table command word fields
    localparam int TBL_HIGH_BIT = 0;
    localparam int TBL_BYTE_BIT = 1;
    localparam int TBL_BSEL_BIT = 2;
    localparam int TBL_WRITE_BIT = 3;
    // Reset values
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // Status bits
    localparam int ST_DONE = 0;
    localparam int ST_FAULT = 1;
    // Operation timing
    localparam int CLOCK_MHZ = 250;
    localparam int OP_TIME_NS = 400;
    localparam int OP_CYCLES = (OP_TIME_NS * CLOCK_MHZ) / 1000;
    localparam logic [7:0] OP_CYCLES_W = 8'(OP_CYCLES);
    // Operation codes
    localparam logic [3:0] OP_BULK = 4'hf;
    localparam logic [3:0] OP_GSEG = 4'hd;
    localparam logic [3:0] OP_SSEG = 4'hc;
    localparam logic [3:0] OP_WORD = 4'h3;
    localparam logic [3:0] OP_PAGE = 4'h2;
    localparam logic [3:0] OP_ROW = 4'h1;
    localparam logic [3:0] OP_CFG = 4'h0;
    typedef struct packed {
        logic go;
        logic erase;
        logic [3:0] op;
    } launch_t;
    typedef struct packed {
        logic req;
        logic write;
        logic [23:0] addr;
        logic [23:0] wdata;
        logic [2:0] lanes;
    } flash_req_t;
endpackage

// File: flash_access.sv
// Table access and flash operation control with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module flash_access
    import flash_access_pkg::*;
(
    // Clock and resets
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic POR,
    // AXI4-Lite slave
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Flash array
    output flash_req_t FLASH_REQ,
    input wire logic [23:0] FLASH_RDATA,
    input wire logic FLASH_ABORT,
    output launch_t FLASH_LAUNCH,
    output logic FLASH_CFG_SPACE,
    // Interrupt
    output logic IRQ
);
    logic [15:0] control;
    logic [7:0] page;
    logic [15:0] addr;
    logic [15:0] data;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] count;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [23:0] rd_word;
    logic rd_busy;
    logic [3:0] rd_cmd;

    function automatic logic valid_op(input logic erase, input logic [3:0] op);
        if (erase)
            valid_op = op == OP_BULK || op == OP_GSEG || op == OP_SSEG || op == OP_PAGE || op == OP_CFG;
        else
            valid_op = op == OP_WORD || op == OP_ROW || op == OP_CFG;
    endfunction

    wire busy = control[GO_BIT];
    wire do_write = aw_held && w_held && !BVALID;
    wire [7:0] wa = aw_addr;
    wire wr_ctrl = do_write && wa == OFF_CONTROL && w_strb[1];
    wire wr_table = do_write && wa == OFF_TABLE && w_strb[0];
    wire want_go = wr_ctrl && w_data[GO_BIT] && !busy;
    wire op_ok = valid_op(w_data[ERASE_BIT], w_data[3:0]);
    wire wr_page = do_write && wa == OFF_PAGE && w_strb[0];
    wire wr_addr = do_write && wa == OFF_ADDR;
    wire wr_data = do_write && wa == OFF_DATA;
    wire wr_mask = do_write && wa == OFF_MASK && w_strb[0];
    wire launch_ok = want_go && control[ENABLE_BIT] && w_data[ENABLE_BIT] && op_ok;
    wire launch_bad = want_go && !launch_ok;
    wire op_end = busy && count == 8'h01;
    wire op_abort = busy && FLASH_ABORT;
    wire next_fault = (launch_bad || op_abort) ? 1'b1 : (launch_ok ? 1'b0 : (wr_ctrl ? w_data[FAULT_BIT] : control[FAULT_BIT]));
    wire rd_take = ARVALID && !rd_busy && !RVALID;
    wire map_rd = ARADDR <= OFF_MASK && ARADDR[1:0] == 2'b00;
    wire map_wr = wa <= OFF_MASK && wa[1:0] == 2'b00;
    wire tbl_high = w_data[TBL_HIGH_BIT];
    wire tbl_byte = w_data[TBL_BYTE_BIT];
    wire tbl_bsel = w_data[TBL_BSEL_BIT];
    // Program address as word index: address steps by two per word
    wire [23:0] prog_addr = {page[6:0], addr[15:1]};
    // Read data shaping for low/high, word/byte
    wire [7:0] low_byte = rd_cmd[2] ? rd_word[15:8] : rd_word[7:0];
    wire [7:0] high_byte = rd_cmd[2] ? 8'h00 : rd_word[23:16];
    wire [15:0] low_val = rd_cmd[1] ? {8'h00, low_byte} : rd_word[15:0];
    wire [15:0] high_val = rd_cmd[1] ? {8'h00, high_byte} : {8'h00, rd_word[23:16]};
    wire [15:0] shaped = rd_cmd[0] ? high_val : low_val;
    // Write lane selection
    wire [2:0] wr_lanes = tbl_high ? (tbl_byte && tbl_bsel ? 3'b000 : 3'b100)
                        : (tbl_byte ? (tbl_bsel ? 3'b010 : 3'b001) : 3'b011);
    wire [23:0] wr_word = tbl_high ? {data[7:0], 16'h0000}
                        : (tbl_byte ? {8'h00, data[7:0], data[7:0]} : {8'h00, data});
    wire [15:0] ctrl_rd = control;

    assign AWREADY = !aw_held;
    assign WREADY = !w_held;
    assign ARREADY = !rd_busy && !RVALID;
    assign IRQ = |(status & mask);
    assign FLASH_CFG_SPACE = page[PAGE_CFG_BIT];
    assign FLASH_LAUNCH = '{go: busy, erase: control[ERASE_BIT], op: control[3:0]};

    // Control register: power-on reset only
    always_ff @(posedge CLOCK) begin
        if (POR) begin
            control <= CONTROL_RESET;
        end else begin
            if (wr_ctrl) begin
                control[ENABLE_BIT] <= w_data[ENABLE_BIT];
            end
            if (wr_ctrl && !busy) begin
                control[ERASE_BIT] <= w_data[ERASE_BIT];
                control[3:0] <= w_data[3:0];
            end
            if (launch_ok) begin
                control[GO_BIT] <= 1'b1;
            end else if (op_abort || op_end) begin
                control[GO_BIT] <= 1'b0;
            end
            control[FAULT_BIT] <= next_fault;
        end
    end

    // Op counter: power-on reset only, so a bus reset cannot strand go
    always_ff @(posedge CLOCK) begin
        if (POR)
            count <= 8'h00;
        else if (launch_ok)
            count <= OP_CYCLES_W;
        else if (busy && count != 8'h00)
            count <= count - 8'h01;
    end

    // Bus write channel
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            BVALID <= 1'b0;
            BRESP <= 2'b00;
        end else begin
            if (AWVALID && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && !w_held) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= map_wr ? 2'b00 : 2'b10;
            end else if (BREADY)
                BVALID <= 1'b0;
        end
    end

    // Page, address, data and table requests
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            page <= PAGE_RESET;
            addr <= 16'h0;
            data <= 16'h0;
            FLASH_REQ <= '0;
            rd_busy <= 1'b0;
            rd_cmd <= 4'h0;
        end else begin
            FLASH_REQ.req <= 1'b0;
            if (wr_page)
                page <= w_data[7:0];
            if (wr_addr) begin
                if (w_strb[0]) addr[7:0] <= w_data[7:0];
                if (w_strb[1]) addr[15:8] <= w_data[15:8];
            end
            if (wr_data) begin
                if (w_strb[0]) data[7:0] <= w_data[7:0];
                if (w_strb[1]) data[15:8] <= w_data[15:8];
            end
            if (wr_table && w_data[TBL_WRITE_BIT]) begin
                FLASH_REQ <= '{req: 1'b1, write: 1'b1, addr: prog_addr, wdata: wr_word, lanes: wr_lanes};
            end else if (wr_table) begin
                FLASH_REQ <= '{req: 1'b1, write: 1'b0, addr: prog_addr, wdata: 24'h0, lanes: 3'b111};
                rd_busy <= 1'b1;
                rd_cmd <= w_data[3:0];
            end
            if (rd_busy) begin
                rd_busy <= 1'b0;
                data <= shaped;
            end
        end
    end

    assign rd_word = FLASH_RDATA;

    // Bus read channel and interrupt status
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= 2'b00;
            status <= IRQ_RESET;
            mask <= IRQ_RESET;
        end else begin
            if (op_end && !op_abort) status[ST_DONE] <= 1'b1;
            if (op_abort || launch_bad) status[ST_FAULT] <= 1'b1;
            if (wr_mask) mask <= w_data[1:0];
            if (rd_take) begin
                RVALID <= 1'b1;
                RRESP <= map_rd ? 2'b00 : 2'b10;
                case (ARADDR)
                    OFF_CONTROL: RDATA <= {16'h0, ctrl_rd};
                    OFF_PAGE: RDATA <= {24'h0, page};
                    OFF_ADDR: RDATA <= {16'h0, addr};
                    OFF_DATA: RDATA <= {16'h0, data};
                    OFF_TABLE: RDATA <= {31'h0, rd_busy};
                    OFF_STATUS: begin
                        RDATA <= {30'h0, status};
                        status <= {op_abort || launch_bad, op_end && !op_abort};
                    end
                    OFF_MASK: RDATA <= {30'h0, mask};
                    default: RDATA <= 32'h0;
                endcase
            end else if (RREADY)
                RVALID <= 1'b0;
        end
    end

    done_clears_go_a: assert property (@(posedge CLOCK) disable iff (POR)
        op_end && !op_abort && !wr_ctrl |=> !control[GO_BIT]) else $error("go bit not cleared at end");
    no_enable_launch_a: assert property (@(posedge CLOCK) disable iff (POR)
        want_go && !control[ENABLE_BIT] |=> !control[GO_BIT]) else $error("launch without enable");
    bad_launch_fault_a: assert property (@(posedge CLOCK) disable iff (POR)
        launch_bad |=> control[FAULT_BIT]) else $error("fault flag not set");
    good_launch_clear_a: assert property (@(posedge CLOCK) disable iff (POR)
        launch_ok |=> !control[FAULT_BIT] && control[GO_BIT]) else $error("fault after good launch");
    phantom_zero_a: assert property (@(posedge CLOCK) disable iff (RST)
        rd_busy && rd_cmd[0] |=> data[15:8] == 8'h00) else $error("phantom byte not zero");
    high_byte_zero_a: assert property (@(posedge CLOCK) disable iff (RST)
        rd_busy && rd_cmd[0] && rd_cmd[1] && rd_cmd[2] |=> data == 16'h0000) else $error("high byte not zero");
    low_word_read_a: assert property (@(posedge CLOCK) disable iff (RST)
        rd_busy && rd_cmd[1:0] == 2'b00 |=> data == $past(FLASH_RDATA[15:0])) else $error("low word wrong");
    go_lasts_a: assert property (@(posedge CLOCK) disable iff (POR || RST)
        launch_ok ##1 !FLASH_ABORT [*3] |-> control[GO_BIT]) else $error("operation ended early");
    page_space_a: assert property (@(posedge CLOCK) disable iff (RST)
        FLASH_REQ.req |-> FLASH_REQ.addr[22:16] == $past(page[6:0]))
        else $error("request page mismatch");
    launch_cov: cover property (@(posedge CLOCK) launch_ok);
    abort_cov: cover property (@(posedge CLOCK) op_abort);
    read_cov: cover property (@(posedge CLOCK) rd_busy);
    irq_cov: cover property (@(posedge CLOCK) IRQ);
    fault_cov: cover property (@(posedge CLOCK) launch_bad);

    // Cycles the current operation has run
    logic [7:0] run_len;
    always_ff @(posedge CLOCK) begin
        if (POR || !busy)
            run_len <= 8'h00;
        else
            run_len <= run_len + 8'h01;
    end

    // Operation timing and control fields
    go_time_a: assert property (@(posedge CLOCK) disable iff (POR)
        busy |-> run_len < OP_CYCLES_W)
        else $error("operation ran too long");
    go_done_a: assert property (@(posedge CLOCK) disable iff (POR)
        busy && run_len == OP_CYCLES_W - 8'h01 |=> !busy)
        else $error("operation did not end");
    abort_fault_a: assert property (@(posedge CLOCK) disable iff (POR)
        op_abort |=> control[FAULT_BIT] && !control[GO_BIT])
        else $error("abort not flagged");
    launch_fields_a: assert property (@(posedge CLOCK) disable iff (POR)
        launch_ok |=> FLASH_LAUNCH.erase == $past(w_data[ERASE_BIT]) && FLASH_LAUNCH.op == $past(w_data[3:0]))
        else $error("launch fields wrong");
    busy_frozen_a: assert property (@(posedge CLOCK) disable iff (POR)
        busy |=> control[3:0] == $past(control[3:0]) && control[ERASE_BIT] == $past(control[ERASE_BIT]))
        else $error("fields changed while busy");
    invalid_op_a: assert property (@(posedge CLOCK) disable iff (POR)
        want_go && !op_ok |=> !control[GO_BIT])
        else $error("invalid code launched");
    rst_keeps_a: assert property (@(posedge CLOCK) disable iff (POR)
        RST && !busy && !wr_ctrl |=> control == $past(control))
        else $error("bus reset changed control");

    // Table requests
    req_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
        FLASH_REQ.req |=> !FLASH_REQ.req) else $error("request longer than one cycle");
    read_order_a: assert property (@(posedge CLOCK) disable iff (RST)
        FLASH_REQ.req && !FLASH_REQ.write |-> rd_busy) else $error("read not tracked");
    write_lanes_a: assert property (@(posedge CLOCK) disable iff (RST)
        FLASH_REQ.req && FLASH_REQ.write && FLASH_REQ.lanes[2] |-> FLASH_REQ.lanes[1:0] == 2'b00)
        else $error("high write touched low word");
    high_write_a: assert property (@(posedge CLOCK) disable iff (RST)
        FLASH_REQ.req && FLASH_REQ.write && FLASH_REQ.lanes[2] |-> FLASH_REQ.wdata[15:0] == 16'h0000)
        else $error("high write data wrong");
    low_write_a: assert property (@(posedge CLOCK) disable iff (RST)
        FLASH_REQ.req && FLASH_REQ.write && !FLASH_REQ.lanes[2] |-> FLASH_REQ.wdata[23:16] == 8'h00)
        else $error("low write touched high byte");

    // Register bus and status
    bresp_ok_a: assert property (@(posedge CLOCK) disable iff (RST)
        do_write && map_wr |=> BVALID && BRESP == 2'b00) else $error("write response wrong");
    bresp_err_a: assert property (@(posedge CLOCK) disable iff (RST)
        do_write && !map_wr |=> BVALID && BRESP == 2'b10) else $error("write error missing");
    bvalid_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
        BVALID && !BREADY |=> BVALID) else $error("write response dropped");
    rvalid_take_a: assert property (@(posedge CLOCK) disable iff (RST)
        rd_take |=> RVALID) else $error("read response missing");
    rresp_err_a: assert property (@(posedge CLOCK) disable iff (RST)
        rd_take && !map_rd |=> RVALID && RRESP == 2'b10 && RDATA == 32'h0) else $error("read error missing");
    rvalid_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
        RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read response dropped");
    ctrl_read_a: assert property (@(posedge CLOCK) disable iff (RST)
        rd_take && ARADDR == OFF_CONTROL |=> RDATA == {16'h0000, $past(control)}) else $error("control read wrong");
    status_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
        rd_take && ARADDR == OFF_STATUS && !op_end && !op_abort && !launch_bad |=> status == 2'b00)
        else $error("status not cleared");
    done_status_a: assert property (@(posedge CLOCK) disable iff (RST || POR)
        op_end && !op_abort |=> status[ST_DONE]) else $error("done status missing");
    fault_status_a: assert property (@(posedge CLOCK) disable iff (RST || POR)
        op_abort || launch_bad |=> status[ST_FAULT]) else $error("fault status missing");
    irq_reset_a: assert property (@(posedge CLOCK)
        RST |=> !IRQ) else $error("interrupt after reset");
endmodule // flash_access
`default_nettype wire

// File: flash_array_model.sv
// Behavioural flash array answering table requests and aborting on command
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
    import flash_access_pkg::*;
(
    // Clock
    input wire logic clock,
    // Array port
    input wire flash_req_t req,
    output logic [23:0] rdata,
    output logic abort,
    // Bench control
    input wire logic abort_cmd,
    output logic [23:0] last_addr
);
    logic [23:0] mem [256];
    logic [23:0] held;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {8'(i) ^ 8'h5a, ~16'(i)};
        end
        held = 24'h000000;
        abort = 1'b0;
        last_addr = 24'h000000;
    end
    // Read word stands only while the read request stands, else scrambled
    assign rdata = (req.req && !req.write) ? mem[req.addr[7:0]] : held;
    always @(posedge clock) begin
        held <= ~held;
        abort <= abort_cmd;
        if (req.req) begin
            last_addr <= req.addr;
            for (int k = 0; k < 3; k++) begin
                if (req.write && req.lanes[k]) begin
                    mem[req.addr[7:0]][8*k +: 8] <= req.wdata[8*k +: 8];
                end
            end
        end
    end
endmodule // flash_array_model
`default_nettype wire

// File: flash_access_bench.sv
// Self-checking bench for table access and flash operation control
`timescale 1ns/1ps
`default_nettype none
module flash_access_bench
    import flash_access_pkg::*;
;
    logic clock = 0, rst = 1, por = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic abort_cmd = 0, awready, wready, bvalid, arready, rvalid, abort, cfg, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [23:0] rdata_a, last_addr;
    logic [1:0] bresp, rresp, resp;
    logic [4:0] codes [8] = '{5'h1f, 5'h1d, 5'h1c, 5'h12, 5'h10, 5'h03, 5'h01, 5'h00};
    flash_req_t req;
    launch_t launch_o;
    int bad_count = 0, checks = 0;
    always #2 clock = ~clock;
    flash_access uut (.CLOCK(clock), .RST(rst), .POR(por), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .FLASH_REQ(req),
        .FLASH_RDATA(rdata_a), .FLASH_ABORT(abort), .FLASH_LAUNCH(launch_o), .FLASH_CFG_SPACE(cfg), .IRQ(irq));
    flash_array_model array (.clock(clock), .req(req), .rdata(rdata_a), .abort(abort),
        .abort_cmd(abort_cmd), .last_addr(last_addr));
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        if (bad_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        resp = bresp;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        rd = rdata;
        resp = rresp;
    endtask
    task tbl(input logic [3:0] cmd, input logic [15:0] a, input logic [15:0] d);
        wr(OFF_ADDR, {16'h0, a});
        wr(OFF_DATA, {16'h0, d});
        wr(OFF_TABLE, {28'h0, cmd});
        do rd_reg(OFF_TABLE);
        while (rd[0]);
        rd_reg(OFF_DATA);
    endtask
    task op(input logic er, input logic [3:0] code, input logic brk);
        wr(OFF_CONTROL, {16'h0, 3'b110, 6'h0, er, 2'b0, code});
        chk("go", launch_o.go, 1);
        chk("erase", launch_o.erase, er);
        chk("op", launch_o.op, code);
        if (brk) begin
            repeat (5) @(posedge clock);
            abort_cmd <= 1;
            @(posedge clock);
            abort_cmd <= 0;
        end
        while (launch_o.go) @(posedge clock);
        rd_reg(OFF_CONTROL);
        chk("go clear", rd[15], 0);
        chk("fault", rd[13], brk);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 0;
        por <= 0;
        rd_reg(OFF_CONTROL);
        chk("ctl reset", rd, 0);
        rd_reg(8'h40);
        chk("bad rresp", resp, 2'b10);
        chk("bad rdata", rd, 0);
        wr(8'h40, 0);
        chk("bad bresp", resp, 2'b10);
        tbl(4'h8, 16'h0010, 16'hbeef);
        chk("req addr", last_addr[14:0], 15'h0008);
        tbl(4'h9, 16'h0010, 16'h00c7);
        tbl(4'h0, 16'h0010, 0);
        chk("low word", rd[15:0], 16'hbeef);
        tbl(4'h1, 16'h0010, 0);
        chk("high word", rd[15:0], 16'h00c7);
        tbl(4'h2, 16'h0010, 0);
        chk("low byte0", rd[7:0], 8'hef);
        tbl(4'h6, 16'h0010, 0);
        chk("low byte1", rd[7:0], 8'hbe);
        tbl(4'h3, 16'h0010, 0);
        chk("high byte0", rd[7:0], 8'hc7);
        tbl(4'h7, 16'h0010, 0);
        chk("phantom", rd[7:0], 8'h00);
        tbl(4'h0, 16'h0012, 0);
        chk("next word", rd[15:0], 16'hfff6);
        wr(OFF_PAGE, 8'h80);
        chk("cfg space", cfg, 1);
        wr(OFF_PAGE, 8'h00);
        chk("user space", cfg, 0);
        wr(OFF_CONTROL, 32'h4000);
        for (int i = 0; i < 8; i++) begin
            op(codes[i][4], codes[i][3:0], 0);
        end
        chk("irq masked", irq, 0);
        wr(OFF_MASK, 1);
        chk("irq", irq, 1);
        rd_reg(OFF_STATUS);
        chk("done", rd[1:0], 2'b01);
        @(posedge clock);
        chk("irq clear", irq, 0);
        op(1, 4'h2, 1);
        wr(OFF_CONTROL, 32'h8003);
        repeat (3) @(posedge clock);
        chk("no launch", launch_o.go, 0);
        rd_reg(OFF_CONTROL);
        chk("no enable fault", rd[13], 1);
        wr(OFF_CONTROL, 32'h4000);
        wr(OFF_PAGE, 8'h80);
        rst <= 1;
        @(posedge clock);
        rst <= 0;
        rd_reg(OFF_CONTROL);
        chk("ctl kept", rd[15:0], 16'h4000);
        rd_reg(OFF_PAGE);
        chk("page reset", rd[7:0], 0);
        por <= 1;
        @(posedge clock);
        por <= 0;
        rd_reg(OFF_CONTROL);
        chk("ctl por", rd, 0);
        give_verdict;
    end
endmodule // flash_access_bench
`default_nettype wire
